//--- core/rom_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - line pin only pulls low through an enable, never drives high.
// - released line rests high; idle suspension keeps the transaction.
// - any long high gap between slots keeps all transaction state.
// - line held low past reset time abandons the transaction.
// - order is reset, rom command, memory command, then data.
// - every transaction begins with master reset and device presence pulse.
// - after presence, eight bits are taken and decoded as rom command.
// - read-identity sends family code, serial number, then crc.
// - match takes 64 bits; selected only if all equal own identity.
// - mismatched device ignores traffic until the next reset.
// - skip goes straight to taking a memory command.
// - search command joins the elimination search.
// - per bit send bit, complement, then read master choice and compare.
// - deselected device stays silent until next reset.
// - identity bits travel least significant first.
module rom_slave #(
   parameter logic [63:0] ROM_ID    = swire_pkg::ID_RESET,
   parameter int          RESET_CYC = swire_pkg::RESET_DET_CYC,
   parameter int          PWAIT_CYC = swire_pkg::PRES_WAIT_CYC,
   parameter int          PLEN_CYC  = swire_pkg::PRES_LEN_CYC,
   parameter int          SMPL_CYC  = swire_pkg::SAMPLE_CYC,
   parameter int          HOLD_CY   = swire_pkg::HOLD_CYC
) (
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_I,
   input  wire logic        DQ_I,
   output logic             DQ_O,
   output logic             DQ_OE_O,
   output logic             SELECTED_O,
   output logic [7:0]       FUNC_CMD_O,
   output logic             FUNC_CMD_VALID_O,
   output logic             LINE_RESET_O
);
   import swire_pkg::*;

   typedef enum logic [3:0] {
      ST_WAIT_RESET,
      ST_ROM_CMD,
      ST_READ_TX,
      ST_MATCH_RX,
      ST_SRCH_BIT,
      ST_SRCH_CMP,
      ST_SRCH_DIR,
      ST_FUNC_CMD,
      ST_DATA,
      ST_SILENT
   } rom_state_e;

   // ------------------------------------------------------------
   // identity layout
   // ------------------------------------------------------------
   logic [7:0]  id_family;
   logic [47:0] id_serial;
   logic [7:0]  id_crc;
   logic [63:0] id_word;

   // family low byte, serial middle, crc top
   assign id_family = ROM_ID[FAMILY_LSB +: 8];
   assign id_serial = ROM_ID[SERIAL_LSB +: 48];
   assign id_crc    = ROM_ID[CRC_LSB +: 8];
   assign id_word   = {id_crc, id_serial, id_family};

   // ------------------------------------------------------------
   // line front end
   // ------------------------------------------------------------
   line_s line;
   slot_s slot;
   tx_s   tx;
   logic  pull;

   line_filter u_filter (
      .clk_i  (CORE_CLK_I),
      .rst_i  (RST_I),
      .pin_i  (DQ_I),
      .line_o (line)
   );

   slot_timer #(
      .RESET_CYC (RESET_CYC),
      .PWAIT_CYC (PWAIT_CYC),
      .PLEN_CYC  (PLEN_CYC),
      .SMPL_CYC  (SMPL_CYC),
      .HOLD_CY   (HOLD_CY)
   ) u_slot (
      .clk_i  (CORE_CLK_I),
      .rst_i  (RST_I),
      .line_i (line),
      .tx_i   (tx),
      .slot_o (slot),
      .pull_o (pull)
   );

   // open drain: level is always low, only the enable moves
   assign DQ_O    = 1'b0;
   assign DQ_OE_O = pull;

   // ------------------------------------------------------------
   // transaction state
   // ------------------------------------------------------------
   rom_state_e      st_q, st_d;
   logic [IDX_W-1:0] idx_q, idx_d;
   logic [7:0]      sh_q, sh_d;
   logic [2:0]      nbit_q, nbit_d;
   logic            sel_q, sel_d;
   logic [7:0]      fcmd_q, fcmd_d;
   logic            fval_q, fval_d;
   logic            lrst_q, lrst_d;
   logic [7:0]      sh_next;
   logic            id_bit;

   // current identity bit, least significant first
   assign id_bit  = id_word[idx_q];
   assign sh_next = {slot.bit_val, sh_q[7:1]};

   // bit to offer in the next slot
   always_comb begin
      tx.en  = 1'b0;
      tx.val = 1'b1;
      unique case (st_q)
         ST_READ_TX: begin
            tx.en  = 1'b1;
            tx.val = id_bit;
         end
         ST_SRCH_BIT: begin
            tx.en  = 1'b1;
            tx.val = id_bit;
         end
         ST_SRCH_CMP: begin
            tx.en  = 1'b1;
            tx.val = ~id_bit;
         end
         default: begin
            tx.en  = 1'b0;
            tx.val = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------
   // rom command decode
   // ------------------------------------------------------------
   rom_state_e cmd_st;
   logic       cmd_sel;

   // next state for each rom command code
   always_comb begin
      cmd_st  = ST_SILENT;
      cmd_sel = 1'b0;
      unique case (sh_next)
         CMD_READ_ID: begin
            cmd_st = ST_READ_TX;
         end
         CMD_MATCH_ID: begin
            cmd_st = ST_MATCH_RX;
         end
         CMD_SKIP_ID: begin
            cmd_st  = ST_FUNC_CMD;
            cmd_sel = 1'b1;
         end
         CMD_SEARCH_ID: begin
            cmd_st = ST_SRCH_BIT;
         end
         default: begin
            cmd_st = ST_SILENT;
         end
      endcase
   end

   // ------------------------------------------------------------
   // rom command sequencer
   // ------------------------------------------------------------
   always_comb begin
      st_d   = st_q;
      idx_d  = idx_q;
      sh_d   = sh_q;
      nbit_d = nbit_q;
      sel_d  = sel_q;
      fcmd_d = fcmd_q;
      fval_d = 1'b0;
      lrst_d = 1'b0;
      if (slot.reset) begin
         // abandon whatever was in progress
         st_d   = ST_WAIT_RESET;
         sel_d  = 1'b0;
         nbit_d = '0;
         lrst_d = 1'b1;
      end else if (slot.pres_done) begin
         // presence sent, a rom command comes next
         st_d   = ST_ROM_CMD;
         nbit_d = '0;
         idx_d  = '0;
      end else if (slot.bit_ok) begin
         unique case (st_q)
            ST_WAIT_RESET: begin
               st_d = ST_WAIT_RESET;
            end
            ST_ROM_CMD: begin
               sh_d   = sh_next;
               nbit_d = nbit_q + 3'h1;
               if (nbit_q == 3'h7) begin
                  // eight bits in, decode the command
                  idx_d = '0;
                  st_d  = cmd_st;
                  sel_d = cmd_sel;
               end
            end
            ST_READ_TX: begin
               // family, serial, crc in one 64-bit walk
               idx_d = idx_q + 6'h01;
               if (idx_q == 6'h3f) begin
                  st_d  = ST_FUNC_CMD;
                  sel_d = 1'b1;
               end
            end
            ST_MATCH_RX: begin
               idx_d = idx_q + 6'h01;
               if (slot.bit_val != id_bit) begin
                  st_d = ST_SILENT;
               end else if (idx_q == 6'h3f) begin
                  st_d  = ST_FUNC_CMD;
                  sel_d = 1'b1;
               end
            end
            ST_SRCH_BIT: begin
               st_d = ST_SRCH_CMP;
            end
            ST_SRCH_CMP: begin
               st_d = ST_SRCH_DIR;
            end
            ST_SRCH_DIR: begin
               idx_d = idx_q + 6'h01;
               if (slot.bit_val != id_bit) begin
                  st_d = ST_SILENT;
               end else if (idx_q == 6'h3f) begin
                  st_d  = ST_FUNC_CMD;
                  sel_d = 1'b1;
               end else begin
                  st_d = ST_SRCH_BIT;
               end
            end
            ST_FUNC_CMD: begin
               sh_d   = sh_next;
               nbit_d = nbit_q + 3'h1;
               if (nbit_q == 3'h7) begin
                  // hand the memory command to the function layer
                  fcmd_d = sh_next;
                  fval_d = 1'b1;
                  st_d   = ST_DATA;
               end
            end
            ST_DATA: begin
               st_d = ST_DATA;
            end
            ST_SILENT: begin
               st_d = ST_SILENT;
            end
            // illegal state code, wait for a line reset
            default: begin
               st_d  = ST_WAIT_RESET;
               sel_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         st_q   <= ST_WAIT_RESET;
         idx_q  <= '0;
         sh_q   <= '0;
         nbit_q <= '0;
         sel_q  <= 1'b0;
         fcmd_q <= '0;
         fval_q <= 1'b0;
         lrst_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         idx_q  <= idx_d;
         sh_q   <= sh_d;
         nbit_q <= nbit_d;
         sel_q  <= sel_d;
         fcmd_q <= fcmd_d;
         fval_q <= fval_d;
         lrst_q <= lrst_d;
      end
   end

   // ------------------------------------------------------------
   // user side outputs
   // ------------------------------------------------------------
   assign SELECTED_O       = sel_q;
   assign FUNC_CMD_O       = fcmd_q;
   assign FUNC_CMD_VALID_O = fval_q;
   assign LINE_RESET_O     = lrst_q;

endmodule : rom_slave
`default_nettype wire

//--- core/swire_pkg.sv
package swire_pkg;

   // ------------------------------------------------------------
   // rom function command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_READ_ID   = 8'h33;
   localparam logic [7:0] CMD_MATCH_ID  = 8'h55;
   localparam logic [7:0] CMD_SKIP_ID   = 8'hcc;
   localparam logic [7:0] CMD_SEARCH_ID = 8'hf0;

   // ------------------------------------------------------------
   // identity layout and widths
   // ------------------------------------------------------------
   localparam int ID_BITS    = 64;
   localparam int IDX_W      = 6;
   localparam int CMD_BITS   = 8;
   localparam int FAMILY_LSB = 0;   // family code byte
   localparam int SERIAL_LSB = 8;   // 48-bit serial number
   localparam int CRC_LSB    = 56;  // crc byte
   // identity value is arbitrary
   localparam logic [63:0] ID_RESET = 64'h9c00_0a1b_2c3d_4e01;

   // ------------------------------------------------------------
   // timing, in ns, and derived cycle counts
   // ------------------------------------------------------------
   localparam int CLK_MHZ          = 250;
   localparam int T_RESET_DET_NS   = 480000;  // least low time taken as reset
   localparam int T_PRES_WAIT_NS   = 30000;   // gap before presence pulse
   localparam int T_PRES_LEN_NS    = 120000;  // presence pulse length
   localparam int T_SAMPLE_NS      = 30000;   // sample point after slot fall
   localparam int T_HOLD_NS        = 30000;   // hold low for a sent zero
   localparam int RESET_DET_CYC    = (T_RESET_DET_NS * CLK_MHZ + 999) / 1000;
   localparam int PRES_WAIT_CYC    = (T_PRES_WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int PRES_LEN_CYC     = (T_PRES_LEN_NS * CLK_MHZ + 999) / 1000;
   localparam int SAMPLE_CYC       = (T_SAMPLE_NS * CLK_MHZ) / 1000;
   localparam int HOLD_CYC         = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W            = 18;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic level;
      logic fall;
      logic rise;
   } line_s;

   typedef struct packed {
      logic reset;      // line held low long enough
      logic pres_done;  // presence pulse finished
      logic bit_ok;     // one slot sampled
      logic bit_val;    // sampled line level
   } slot_s;

   typedef struct packed {
      logic en;
      logic val;
   } tx_s;

endpackage : swire_pkg

//--- core/line_filter.sv
`timescale 1ns/1ps
`default_nettype none
module line_filter (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          pin_i,
   output swire_pkg::line_s   line_o
);
   import swire_pkg::*;

   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic       level_q;
   logic       level_d;
   logic       prev_q;
   logic       prev_d;

   // ------------------------------------------------------------
   // three-stage sampler, level moves when last two agree
   // ------------------------------------------------------------
   always_comb begin
      sync_d  = {sync_q[1:0], pin_i};
      level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
      prev_d  = level_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_q  <= 3'h7;
         level_q <= 1'b1;
         prev_q  <= 1'b1;
      end else begin
         sync_q  <= sync_d;
         level_q <= level_d;
         prev_q  <= prev_d;
      end
   end

   // edges of the filtered level
   always_comb begin
      line_o.level = level_q;
      line_o.fall  = prev_q & ~level_q;
      line_o.rise  = ~prev_q & level_q;
   end

endmodule : line_filter
`default_nettype wire

//--- core/slot_timer.sv
`timescale 1ns/1ps
`default_nettype none
module slot_timer #(
   parameter int RESET_CYC = swire_pkg::RESET_DET_CYC,
   parameter int PWAIT_CYC = swire_pkg::PRES_WAIT_CYC,
   parameter int PLEN_CYC  = swire_pkg::PRES_LEN_CYC,
   parameter int SMPL_CYC  = swire_pkg::SAMPLE_CYC,
   parameter int HOLD_CY   = swire_pkg::HOLD_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire swire_pkg::line_s  line_i,
   input  wire swire_pkg::tx_s    tx_i,
   output swire_pkg::slot_s       slot_o,
   output logic                   pull_o
);
   import swire_pkg::*;

   localparam int END_CYC = (SMPL_CYC > HOLD_CY) ? SMPL_CYC : HOLD_CY;

   typedef enum logic [2:0] {ST_IDLE, ST_SLOT, ST_HELD, ST_PWAIT, ST_PDRIVE} slot_state_e;

   slot_state_e      st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] low_q, low_d;
   logic             pull_q, pull_d;
   slot_s            ev_q, ev_d;

   // ------------------------------------------------------------
   // slot, reset and presence sequencing
   // ------------------------------------------------------------
   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q + CNT_W'(1);
      pull_d = pull_q;
      ev_d   = '0;
      // low time counted whoever holds the line; own pulls are far shorter
      low_d  = line_i.level ? '0 : low_q + CNT_W'(1);
      unique case (st_q)
         ST_IDLE: begin
            if (line_i.fall) begin
               st_d   = ST_SLOT;
               cnt_d  = '0;
               pull_d = tx_i.en & ~tx_i.val;
            end
         end
         ST_SLOT: begin
            if (cnt_q == CNT_W'(HOLD_CY - 1)) begin
               pull_d = 1'b0;
            end
            if (cnt_q == CNT_W'(SMPL_CYC - 1)) begin
               ev_d.bit_ok  = 1'b1;
               ev_d.bit_val = line_i.level;
            end
            if (cnt_q == CNT_W'(END_CYC - 1)) begin
               st_d = ST_IDLE;
            end
         end
         ST_HELD: begin
            if (line_i.rise) begin
               st_d  = ST_PWAIT;
               cnt_d = '0;
            end
         end
         ST_PWAIT: begin
            if (cnt_q == CNT_W'(PWAIT_CYC - 1)) begin
               st_d   = ST_PDRIVE;
               cnt_d  = '0;
               pull_d = 1'b1;
            end
         end
         ST_PDRIVE: begin
            if (cnt_q == CNT_W'(PLEN_CYC - 1)) begin
               st_d           = ST_IDLE;
               pull_d         = 1'b0;
               ev_d.pres_done = 1'b1;
            end
         end
         default: begin
            st_d   = ST_IDLE;
            pull_d = 1'b0;
         end
      endcase
      // a long low level overrides any slot in progress
      if (low_q == CNT_W'(RESET_CYC - 1) && !line_i.level) begin
         st_d       = ST_HELD;
         pull_d     = 1'b0;
         ev_d.reset = 1'b1;
      end
      if (st_q == ST_HELD) begin
         low_d = low_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q   <= ST_IDLE;
         cnt_q  <= '0;
         low_q  <= '0;
         pull_q <= 1'b0;
         ev_q   <= '0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         low_q  <= low_d;
         pull_q <= pull_d;
         ev_q   <= ev_d;
      end
   end

   assign slot_o = ev_q;
   assign pull_o = pull_q;

endmodule : slot_timer
`default_nettype wire

//--- test/rom_slave_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rom_slave_assertions #(
   parameter int RESET_CYC = swire_pkg::RESET_DET_CYC,
   parameter int PLEN_CYC  = swire_pkg::PRES_LEN_CYC,
   parameter int HOLD_CY   = swire_pkg::HOLD_CYC
) (
   input wire logic       CORE_CLK_I,
   input wire logic       RST_I,
   input wire logic       DQ_I,
   input wire logic       DQ_O,
   input wire logic       DQ_OE_O,
   input wire logic       SELECTED_O,
   input wire logic [7:0] FUNC_CMD_O,
   input wire logic       FUNC_CMD_VALID_O,
   input wire logic       LINE_RESET_O
);
   int low_cnt_q;
   int low_cnt_d;
   int oe_cnt_q;
   int oe_cnt_d;

   // ----------------------------------------
   // run lengths of low line and device pull
   // ----------------------------------------
   always_comb begin
      low_cnt_d = DQ_I ? 0 : low_cnt_q + 1;
      oe_cnt_d  = DQ_OE_O ? oe_cnt_q + 1 : 0;
   end

   // register the run lengths
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         low_cnt_q <= 0;
         oe_cnt_q  <= 0;
      end else begin
         low_cnt_q <= low_cnt_d;
         oe_cnt_q  <= oe_cnt_d;
      end
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);

   chk_open_drain: assert property (DQ_O == 1'b0)
      else $error("pin drives a high value");
   chk_pull_bounded: assert property (low_cnt_q > PLEN_CYC + 8 |-> !DQ_OE_O)
      else $error("device holds line low too long");
   chk_pull_length: assert property ($fell(DQ_OE_O) |->
      (oe_cnt_q + 1 >= HOLD_CY && oe_cnt_q <= PLEN_CYC + 1))
      else $error("pull length out of range");
   chk_reset_cause: assert property (LINE_RESET_O |-> low_cnt_q >= RESET_CYC)
      else $error("line reset without long low");
   chk_reset_pulse: assert property (LINE_RESET_O |=> !LINE_RESET_O)
      else $error("line reset pulse too long");
   chk_reset_deselect: assert property (LINE_RESET_O |-> ##[0:1] !SELECTED_O)
      else $error("selection survives line reset");
   chk_sel_kept: assert property ($fell(SELECTED_O) |-> LINE_RESET_O || $past(LINE_RESET_O))
      else $error("selection lost without line reset");
   chk_valid_sel: assert property (FUNC_CMD_VALID_O |-> SELECTED_O)
      else $error("memory command taken while unselected");
   chk_valid_once: assert property (FUNC_CMD_VALID_O |=> !FUNC_CMD_VALID_O [*8])
      else $error("memory command pulse repeated");
   chk_cmd_hold: assert property ($changed(FUNC_CMD_O) |-> FUNC_CMD_VALID_O)
      else $error("command output changed without valid");
endmodule : rom_slave_assertions

bind rom_slave rom_slave_assertions #(
   .RESET_CYC(RESET_CYC), .PLEN_CYC(PLEN_CYC), .HOLD_CY(HOLD_CY)
) u_chk (
   .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .DQ_I(DQ_I), .DQ_O(DQ_O),
   .DQ_OE_O(DQ_OE_O), .SELECTED_O(SELECTED_O), .FUNC_CMD_O(FUNC_CMD_O),
   .FUNC_CMD_VALID_O(FUNC_CMD_VALID_O), .LINE_RESET_O(LINE_RESET_O)
);
`default_nettype wire

//--- test/line_master.sv
`timescale 1ns/1ps
`default_nettype none
module line_master (
   input  wire logic clk_i,
   input  wire logic dev_pull_i,
   output logic      line_o
);
   logic drv_low;

   // ----------------------------------------
   // wired line with pull-up
   // ----------------------------------------
   assign line_o = !(drv_low | dev_pull_i);
   initial drv_low = 1'b0;

   // pull low for n cycles, then release to idle high
   task automatic low_for(input int n);
      @(posedge clk_i);
      #1 drv_low = 1'b1;
      repeat (n) @(posedge clk_i);
      #1 drv_low = 1'b0;
   endtask : low_for

   // reset pulse, then sample presence
   task automatic line_reset(output logic pres);
      low_for(220);
      repeat (25) @(posedge clk_i);
      #1 pres = !line_o;
      repeat (60) @(posedge clk_i);
   endtask : line_reset

   // write slot, short low for one
   task automatic wr_bit(input logic b);
      low_for(b ? 4 : 40);
      repeat (30) @(posedge clk_i);
   endtask : wr_bit

   // read slot, sample mid slot
   task automatic rd_bit(output logic b);
      low_for(2);
      repeat (12) @(posedge clk_i);
      #1 b = line_o;
      repeat (30) @(posedge clk_i);
   endtask : rd_bit
endmodule : line_master
`default_nettype wire

//--- test/single_wire_rom_command_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none
module single_wire_rom_command_slave_bench;
   import swire_pkg::*;
   // identity value is arbitrary
   localparam logic [63:0] DEV_ID = 64'h5a3c_0f12_7788_e441;
   logic       clk, rst, line, dq_o, oe, sel, valid, lreset;
   logic [7:0] fcmd;
   logic [15:0] seed;
   int         failures, checked, vcnt, rcnt;
   logic       exp_bits[$];  // model: identity bits in bus order

   line_master m (.clk_i(clk), .dev_pull_i(oe), .line_o(line));
   rom_slave #(.ROM_ID(DEV_ID), .RESET_CYC(200), .PWAIT_CYC(10), .PLEN_CYC(40),
      .SMPL_CYC(20), .HOLD_CY(20)) dut (
      .CORE_CLK_I(clk), .RST_I(rst), .DQ_I(line), .DQ_O(dq_o), .DQ_OE_O(oe),
      .SELECTED_O(sel), .FUNC_CMD_O(fcmd), .FUNC_CMD_VALID_O(valid),
      .LINE_RESET_O(lreset)
   );

   // ----------------------------------------
   // clock and pulse counters
   // ----------------------------------------
   initial clk = 1'b0;
   always #2 clk = !clk;
   always @(posedge clk) begin
      if (valid === 1'b1) vcnt++;
      if (lreset === 1'b1) rcnt++;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic complete_run;
      if (failures == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   task automatic send8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) m.wr_bit(v[i]);
   endtask : send8

   task automatic send64(input logic [63:0] v);
      for (int i = 0; i < 64; i++) m.wr_bit(v[i]);
   endtask : send64

   // model of the identity stream, least significant bit first
   task automatic model_id(input logic [63:0] v);
      exp_bits.delete();
      for (int i = 0; i < 64; i++) exp_bits.push_back(v[i]);
   endtask : model_id

   // line reset, presence, rom command with optional idle gap
   task automatic start(input logic [7:0] c, input int gap);
      logic p;
      int   r0;
      r0 = rcnt;
      m.line_reset(p);
      chk("presence", 1, p);
      chk("line_reset", r0 + 1, rcnt);
      chk("sel_cleared", 0, sel);
      for (int i = 0; i < 8; i++) begin
         if (i == 4) repeat (gap) @(posedge clk);
         m.wr_bit(c[i]);
      end
   endtask : start

   // random memory command, then selection outcome
   task automatic mem(input logic want);
      logic [7:0] c;
      int         v0;
      seed = lfsr(seed);
      c = seed[7:0];
      v0 = vcnt;
      send8(c);
      chk("selected", want, sel);
      chk("cmd_valid", want, vcnt - v0);
      if (want) chk("func_cmd", c, fcmd);
   endtask : mem

   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   initial begin
      #300000;
      failures++;
      complete_run();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [63:0] id;
      logic [7:0]  c;
      logic        b0, b1;
      int          bad;
      rst = 1'b1;
      seed = 16'h752e;
      failures = 0;
      checked = 0;
      vcnt = 0;
      rcnt = 0;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      // read identity, then memory command
      start(CMD_READ_ID, 0);
      model_id(DEV_ID);
      for (int i = 0; i < 64; i++) begin
         m.rd_bit(id[i]);
         chk("read_bit", exp_bits.pop_front(), id[i]);
      end
      chk("read_id", DEV_ID, id);
      mem(1'b1);
      // read cut by a reset whose slot finds the device sending a zero
      start(CMD_READ_ID, 0);
      m.rd_bit(b0);
      chk("read_bit0", DEV_ID[0], b0);
      // skip with a long high gap inside the command
      start(CMD_SKIP_ID, 3000);
      mem(1'b1);
      // match aborted mid-code, then full match
      start(CMD_MATCH_ID, 0);
      send8(DEV_ID[7:0]);
      start(CMD_MATCH_ID, 0);
      send64(DEV_ID);
      mem(1'b1);
      // match with one wrong bit
      seed = lfsr(seed);
      start(CMD_MATCH_ID, 0);
      send64(DEV_ID ^ (64'h1 << seed[5:0]));
      mem(1'b0);
      m.rd_bit(b0);
      chk("silent_match", 1, b0);
      // search: full pass, then pass with a wrong choice
      for (int p = 0; p < 2; p++) begin
         seed = lfsr(seed);
         bad = p ? int'(seed[5:0]) : 64;
         start(CMD_SEARCH_ID, 0);
         for (int i = 0; i < 64; i++) begin
            m.rd_bit(b0);
            m.rd_bit(b1);
            chk("search_bit", i <= bad ? DEV_ID[i] : 1'b1, b0);
            chk("search_cmp", i <= bad ? !DEV_ID[i] : 1'b1, b1);
            m.wr_bit(i == bad ? !DEV_ID[i] : DEV_ID[i]);
         end
         mem(p == 0);
      end
      // unknown rom command
      do begin
         seed = lfsr(seed);
         c = seed[7:0];
      end while (c == CMD_READ_ID || c == CMD_MATCH_ID || c == CMD_SKIP_ID || c == CMD_SEARCH_ID);
      start(c, 0);
      mem(1'b0);
      m.rd_bit(b0);
      chk("silent_unknown", 1, b0);
      complete_run();
   end
endmodule : single_wire_rom_command_slave_bench
`default_nettype wire
